// ### hdl/multi_input_wakeup_pkg.sv
// Purpose: Shared constants for the multi-input wake-up and interrupt block.
// Assumes: Avalon-MM byte addressing, one byte-wide register per word.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package multi_input_wakeup_pkg;
    localparam int unsigned   MULTI_INPUT_WAKEUP_ADDR_W         = 6;
    localparam int unsigned   MULTI_INPUT_WAKEUP_L_PINS         = 8;
    localparam int unsigned   MULTI_INPUT_WAKEUP_M_PINS         = 8;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_L_EN       = 6'h00;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_L_EDGE     = 6'h04;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_L_PEND     = 6'h08;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_M_EN       = 6'h0c;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_M_EDGE     = 6'h10;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_M_PEND     = 6'h14;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_CTRL       = 6'h18;
    localparam logic [5:0]    MULTI_INPUT_WAKEUP_OFF_STATUS     = 6'h1c;
    // Control register fields.
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_PIE       = 0;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_GIE       = 1;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_HALT      = 2;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_IDLE      = 3;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_0     = 4;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_1     = 5;
    // Status register fields.
    localparam int unsigned   MULTI_INPUT_WAKEUP_ST_IRQ         = 0;
    localparam int unsigned   MULTI_INPUT_WAKEUP_ST_STOPPED     = 1;
    localparam int unsigned   MULTI_INPUT_WAKEUP_ST_STARTUP     = 2;
    localparam int unsigned   MULTI_INPUT_WAKEUP_ST_REFUSED     = 3;
    localparam int unsigned   MULTI_INPUT_WAKEUP_ST_RESUME_ISR  = 4;
    localparam logic [7:0]    MULTI_INPUT_WAKEUP_RST_BYTE       = 8'h00;
    localparam logic [31:0]   MULTI_INPUT_WAKEUP_UNMAPPED_RD    = 32'h0000_0000;
    // Start-up delay in instruction cycles; instruction cycle is osc / 10.
    localparam int unsigned   MULTI_INPUT_WAKEUP_STARTUP_CYCLES = 256;
    localparam int unsigned   MULTI_INPUT_WAKEUP_OSC_DIV        = 10;
    localparam int unsigned   MULTI_INPUT_WAKEUP_CAN_BIT        = 7;
    typedef enum logic [1:0] {
        MULTI_INPUT_WAKEUP_RUN     = 2'b00,
        MULTI_INPUT_WAKEUP_STOPPED = 2'b01,
        MULTI_INPUT_WAKEUP_STARTUP = 2'b11
    } multi_input_wakeup_mode_e;
endpackage

// ### hdl/multi_input_wakeup_top.sv
// Purpose: Multi-input wake-up, port interrupt and start-up delay logic for
//          Port L, Port M and the CAN receive line, with an Avalon-MM slave.
// Assumes: One clock i_clk (125 MHz) standing for the oscillator; pins async.
// Notes:   The core stop request is a register bit; the core sees o_core_run.
`timescale 1ns/1ps
`default_nettype none
module multi_input_wakeup_top #(
    parameter int unsigned L_PINS = multi_input_wakeup_pkg::MULTI_INPUT_WAKEUP_L_PINS,
    parameter int unsigned M_PINS = multi_input_wakeup_pkg::MULTI_INPUT_WAKEUP_M_PINS
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst,
    input  wire logic [multi_input_wakeup_pkg::MULTI_INPUT_WAKEUP_ADDR_W-1:0] i_address,
    input  wire logic                             i_read,
    input  wire logic                             i_write,
    input  wire logic [31:0]                      i_writedata,
    output logic      [31:0]                      o_readdata,
    output logic                                  o_waitrequest,
    input  wire logic [L_PINS-1:0]                i_port_l,
    input  wire logic [M_PINS-2:0]                i_port_m,
    input  wire logic                             i_can_receive_input,
    output logic                                  o_port_irq,
    output logic                                  o_core_run,
    output logic                                  o_resume_isr,
    output logic                                  o_can_drive_enable_0,
    output logic                                  o_can_drive_enable_1
);
    import multi_input_wakeup_pkg::*;

    localparam int unsigned N = L_PINS + M_PINS;
    localparam int unsigned DIV_W = $clog2(MULTI_INPUT_WAKEUP_OSC_DIV);
    localparam int unsigned CNT_W = $clog2(MULTI_INPUT_WAKEUP_STARTUP_CYCLES) + 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MULTI_INPUT_WAKEUP_OSC_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(MULTI_INPUT_WAKEUP_STARTUP_CYCLES);
    // The CAN receive line idles recessive (one), so its synchroniser starts high.
    // Starting it low would fake a rising edge and set pending bit 7 after reset.
    localparam logic [N-1:0]     IDLE_PINS = {1'b1, {(N-1){1'b0}}};

    typedef struct packed {
        logic [N-1:0]       sync1;
        logic [N-1:0]       sync2;
        logic [N-1:0]       sync3;
        logic [N-1:0]       wake_enable;
        logic [N-1:0]       edge_select;
        logic [N-1:0]       wake_pending;
        logic               port_irq_enable;
        logic               global_irq_enable;
        logic               can_drive_enable_0;
        logic               can_drive_enable_1;
        logic               refused;
        logic               resume_isr;
        multi_input_wakeup_mode_e         mode;
        logic [DIV_W-1:0]   div;
        logic [CNT_W-1:0]   startup_delay_counter;
        logic [31:0]        readdata;
        logic               waitrequest;
        logic               port_irq;
        logic               core_run;
    } multi_input_wakeup_state_s;

    multi_input_wakeup_state_s state_q;
    multi_input_wakeup_state_s state_d;

    logic [N-1:0] pins;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] hit;
    logic [N-1:0] irq_src_mask;

    // Port L occupies the low bits, Port M the high bits; CAN receive is M7.
    assign pins = {i_can_receive_input, i_port_m, i_port_l};

    // The CAN position never feeds the interrupt, only pending and wake.
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gen_pin
            // Edges are judged only between the second and third stages.
            assign rise[g] = state_q.sync2[g] & ~state_q.sync3[g];
            assign fall[g] = ~state_q.sync2[g] & state_q.sync3[g];
            // One selects falling, zero selects rising.
            assign hit[g] = state_q.edge_select[g] ? fall[g] : rise[g];
            assign irq_src_mask[g] = (g != L_PINS + MULTI_INPUT_WAKEUP_CAN_BIT);
        end
    endgenerate

    always_comb
    begin
        logic [N-1:0]     armed;
        logic             any_armed;
        logic             any_irq;
        logic [N-1:0]     clr_pend;
        logic [N-1:0]     wr_pend;
        logic             wr_pend_en;
        logic [7:0]       wd;
        logic [31:0]      rd;
        logic             access;
        logic             stop_req;
        armed      = '0;
        any_armed  = 1'b0;
        any_irq    = 1'b0;
        clr_pend   = '0;
        wr_pend    = '0;
        wr_pend_en = 1'b0;
        wd         = i_writedata[7:0];
        rd         = MULTI_INPUT_WAKEUP_UNMAPPED_RD;
        stop_req   = 1'b0;
        state_d    = state_q;

        state_d.sync1 = pins;
        state_d.sync2 = state_q.sync1;
        state_d.sync3 = state_q.sync2;

        // One-cycle wait state: requests are answered on the edge after they appear.
        access = (i_read | i_write) & state_q.waitrequest;
        state_d.waitrequest = ~access;

        if (access && i_write)
        begin
            if (i_address == MULTI_INPUT_WAKEUP_OFF_L_EN)
                state_d.wake_enable[L_PINS-1:0] = wd[L_PINS-1:0];
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_L_EDGE)
                state_d.edge_select[L_PINS-1:0] = wd[L_PINS-1:0];
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_L_PEND)
            begin
                wr_pend[L_PINS-1:0] = wd[L_PINS-1:0];
                clr_pend[L_PINS-1:0] = ~wd[L_PINS-1:0];
                wr_pend_en = 1'b1;
            end
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_EN)
                state_d.wake_enable[N-1:L_PINS] = wd[M_PINS-1:0];
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_EDGE)
                state_d.edge_select[N-1:L_PINS] = wd[M_PINS-1:0];
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_PEND)
            begin
                wr_pend[N-1:L_PINS] = wd[M_PINS-1:0];
                clr_pend[N-1:L_PINS] = ~wd[M_PINS-1:0];
                wr_pend_en = 1'b1;
            end
            else if (i_address == MULTI_INPUT_WAKEUP_OFF_CTRL)
            begin
                state_d.port_irq_enable = wd[MULTI_INPUT_WAKEUP_CTRL_PIE];
                state_d.global_irq_enable = wd[MULTI_INPUT_WAKEUP_CTRL_GIE];
                state_d.can_drive_enable_0 = wd[MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_0];
                state_d.can_drive_enable_1 = wd[MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_1];
                stop_req = wd[MULTI_INPUT_WAKEUP_CTRL_HALT] | wd[MULTI_INPUT_WAKEUP_CTRL_IDLE];
            end
        end

        // Software may write ones or zeros; a fresh edge beats a clear.
        if (wr_pend_en)
            state_d.wake_pending = (state_q.wake_pending & ~clr_pend) | wr_pend | hit;
        else
            state_d.wake_pending = state_q.wake_pending | hit;

        armed = state_q.wake_enable & state_q.wake_pending;
        any_armed = |armed;
        // Interrupt straight from enabled pending bits, both gates needed.
        any_irq = |(armed & irq_src_mask) & state_q.port_irq_enable
                  & state_q.global_irq_enable;
        state_d.port_irq = any_irq;

        // Wake-up sequencing.
        case (state_q.mode)
            MULTI_INPUT_WAKEUP_RUN:
            begin
                if (stop_req)
                begin
                    if (any_armed)
                        state_d.refused = 1'b1;
                    else
                    begin
                        state_d.refused = 1'b0;
                        state_d.mode = MULTI_INPUT_WAKEUP_STOPPED;
                    end
                end
            end
            MULTI_INPUT_WAKEUP_STOPPED:
            begin
                if (any_armed)
                begin
                    // Only the divider and start-up counter run from here.
                    state_d.mode = MULTI_INPUT_WAKEUP_STARTUP;
                    state_d.div = '0;
                    state_d.startup_delay_counter = CNT_LOAD;
                    // With the interrupt on, the core finishes its pending no-op
                    // and then vectors; otherwise it resumes in line.
                    state_d.resume_isr = any_irq;
                end
            end
            MULTI_INPUT_WAKEUP_STARTUP:
            begin
                if (state_q.div == DIV_LAST)
                begin
                    state_d.div = '0;
                    state_d.startup_delay_counter = state_q.startup_delay_counter - 1'b1;
                    if (state_q.startup_delay_counter == CNT_W'(1))
                        state_d.mode = MULTI_INPUT_WAKEUP_RUN;
                end
                else
                    state_d.div = state_q.div + 1'b1;
            end
            default:
                state_d.mode = MULTI_INPUT_WAKEUP_RUN;
        endcase
        state_d.core_run = (state_d.mode == MULTI_INPUT_WAKEUP_RUN);

        if (i_address == MULTI_INPUT_WAKEUP_OFF_L_EN)
            rd[L_PINS-1:0] = state_q.wake_enable[L_PINS-1:0];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_L_EDGE)
            rd[L_PINS-1:0] = state_q.edge_select[L_PINS-1:0];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_L_PEND)
            rd[L_PINS-1:0] = state_q.wake_pending[L_PINS-1:0];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_EN)
            rd[M_PINS-1:0] = state_q.wake_enable[N-1:L_PINS];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_EDGE)
            rd[M_PINS-1:0] = state_q.edge_select[N-1:L_PINS];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_M_PEND)
            rd[M_PINS-1:0] = state_q.wake_pending[N-1:L_PINS];
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_CTRL)
        begin
            rd[MULTI_INPUT_WAKEUP_CTRL_PIE] = state_q.port_irq_enable;
            rd[MULTI_INPUT_WAKEUP_CTRL_GIE] = state_q.global_irq_enable;
            rd[MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_0] = state_q.can_drive_enable_0;
            rd[MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_1] = state_q.can_drive_enable_1;
        end
        else if (i_address == MULTI_INPUT_WAKEUP_OFF_STATUS)
        begin
            rd[MULTI_INPUT_WAKEUP_ST_IRQ] = state_q.port_irq;
            rd[MULTI_INPUT_WAKEUP_ST_STOPPED] = (state_q.mode == MULTI_INPUT_WAKEUP_STOPPED);
            rd[MULTI_INPUT_WAKEUP_ST_STARTUP] = (state_q.mode == MULTI_INPUT_WAKEUP_STARTUP);
            rd[MULTI_INPUT_WAKEUP_ST_REFUSED] = state_q.refused;
            rd[MULTI_INPUT_WAKEUP_ST_RESUME_ISR] = state_q.resume_isr;
        end
        state_d.readdata = (access && i_read) ? rd : MULTI_INPUT_WAKEUP_UNMAPPED_RD;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q <= '0;
            state_q.wake_enable <= {N{1'b0}};
            state_q.sync1 <= IDLE_PINS;
            state_q.sync2 <= IDLE_PINS;
            state_q.sync3 <= IDLE_PINS;
            state_q.mode <= MULTI_INPUT_WAKEUP_RUN;
            state_q.waitrequest <= 1'b1;
            state_q.core_run <= 1'b1;
        end
        else
            state_q <= state_d;
    end

    assign o_readdata = state_q.readdata;
    assign o_waitrequest = state_q.waitrequest;
    assign o_port_irq = state_q.port_irq;
    assign o_core_run = state_q.core_run;
    assign o_resume_isr = state_q.resume_isr;
    assign o_can_drive_enable_0 = state_q.can_drive_enable_0;
    assign o_can_drive_enable_1 = state_q.can_drive_enable_1;
endmodule
`default_nettype wire

// ### verification/multi_input_wakeup_monitor.sv
// Purpose: Port-level checks of the wake-up and port interrupt block.
// Assumes: Bound to multi_input_wakeup_top; one clock domain.
// Notes:   Control bits are shadowed from accepted bus writes.
`timescale 1ns/1ps
`default_nettype none
module multi_input_wakeup_monitor (
    input wire logic                             i_clk,
    input wire logic                             i_rst,
    input wire logic [multi_input_wakeup_pkg::MULTI_INPUT_WAKEUP_ADDR_W-1:0] i_address,
    input wire logic                             i_read,
    input wire logic                             i_write,
    input wire logic [31:0]                      i_writedata,
    input wire logic [31:0]                      o_readdata,
    input wire logic                             o_waitrequest,
    input wire logic                             o_port_irq,
    input wire logic                             o_core_run,
    input wire logic                             o_resume_isr,
    input wire logic                             o_can_drive_enable_0
);
    import multi_input_wakeup_pkg::*;
    localparam int START = MULTI_INPUT_WAKEUP_STARTUP_CYCLES * MULTI_INPUT_WAKEUP_OSC_DIV;
    logic        ctl_w;
    logic [1:0]  gate_q;
    logic        en0_q;
    logic [15:0] low_q;
    assign ctl_w = i_write && !o_waitrequest && (i_address == MULTI_INPUT_WAKEUP_OFF_CTRL);
    // The low-time counter spans stop and start-up, so it only bounds from below.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            gate_q <= 2'b00;
            en0_q  <= 1'b0;
            low_q  <= 16'h0000;
        end
        else
        begin
            gate_q <= ctl_w ? i_writedata[1:0] : gate_q;
            en0_q  <= ctl_w ? i_writedata[MULTI_INPUT_WAKEUP_CTRL_CAN_DRIVE_ENABLE_0] : en0_q;
            low_q  <= o_core_run ? 16'h0000 : low_q + 16'h0001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer: assert property ($rose(i_read || i_write) |=> !o_waitrequest)
        else $error("access not answered on the next edge");
    a_idle_zero: assert property (o_waitrequest |-> o_readdata == 32'h0000_0000)
        else $error("read data not zero while idle");
    a_byte_regs: assert property (!o_waitrequest |-> o_readdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    a_reset_state: assert property ($past(i_rst) |-> o_core_run && !o_port_irq && !o_resume_isr)
        else $error("outputs not at reset values");
    a_irq_gated: assert property (o_port_irq |-> gate_q == 2'b11)
        else $error("port interrupt without both enables");
    a_irq_latched: assert property (o_port_irq && !i_write && !$past(i_write) |=> o_port_irq)
        else $error("port interrupt dropped without software clear");
    a_drive_follow: assert property (ctl_w |-> ##2 (o_can_drive_enable_0 == en0_q))
        else $error("drive enable does not follow control write");
    a_startup_len: assert property ($rose(o_core_run) |-> low_q >= START)
        else $error("clocks released before start-up delay");
    c_wake: cover property ($rose(o_core_run));
    c_irq: cover property ($rose(o_port_irq));
    c_isr: cover property ($rose(o_resume_isr));
endmodule
`default_nettype wire

// ### verification/multi_input_wakeup_pins_model.sv
// Purpose: Far side of the block: Port L, Port M pins and the CAN receive line.
// Assumes: The bench sets levels; pins move just after a clock edge.
// Notes:   The CAN line idles recessive, which reads as one.
`timescale 1ns/1ps
`default_nettype none
module multi_input_wakeup_pins_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_l_lvl,
    input  wire logic [6:0] i_m_lvl,
    input  wire logic       i_can_dom,
    output var  logic [7:0] o_port_l,
    output var  logic [6:0] o_port_m,
    output var  logic       o_can_rx
);
    initial
    begin
        o_port_l = 8'h00;
        o_port_m = 7'h00;
        o_can_rx = 1'b1;
    end
    always @(posedge i_clk)
    begin
        o_port_l <= i_l_lvl;
        o_port_m <= i_m_lvl;
        o_can_rx <= !i_can_dom;
    end
endmodule
`default_nettype wire

// ### verification/multi_input_wakeup_top_bench.sv
// Purpose: Self-checking bench for the wake-up and port interrupt block.
// Assumes: Avalon-MM master held until waitrequest is sampled low.
// Notes:   Pins settle through three sync stages, so edges get eight cycles.
`timescale 1ns/1ps
`default_nettype none
module multi_input_wakeup_top_bench;
    import multi_input_wakeup_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [5:0]  i_address = 6'h00;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0000_0000;
    logic [7:0]  l_lvl = 8'h00;
    logic [6:0]  m_lvl = 7'h00;
    logic        can_dom = 1'b0;
    logic [31:0] o_readdata, q;
    logic        o_waitrequest, o_port_irq, o_core_run, o_resume_isr, o_en0, o_en1, can_rx;
    logic [7:0]  port_l;
    logic [6:0]  port_m;
    int          num_errors = 0;
    int          n_checks = 0;
    multi_input_wakeup_pins_model i_multi_input_wakeup_pins_model (.i_clk(i_clk), .i_l_lvl(l_lvl), .i_m_lvl(m_lvl),
        .i_can_dom(can_dom), .o_port_l(port_l), .o_port_m(port_m), .o_can_rx(can_rx));
    multi_input_wakeup_top i_multi_input_wakeup_top (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_port_l(port_l),
        .i_port_m(port_m), .i_can_receive_input(can_rx), .o_port_irq(o_port_irq),
        .o_core_run(o_core_run), .o_resume_isr(o_resume_isr),
        .o_can_drive_enable_0(o_en0), .o_can_drive_enable_1(o_en1));
    always #4 i_clk = ~i_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= {24'h00_0000, d};
        i_write <= wr;
        i_read <= !wr;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h00_0000, e}, q);
    endtask
    task automatic pins(input logic m, input logic [7:0] v);
        @(posedge i_clk);
        if (m)
        begin
            m_lvl <= v[6:0];
            can_dom <= !v[7];
        end
        else
            l_lvl <= v;
        cyc(8);
    endtask
    task automatic t_regs;
        for (int k = 0; k < 9; k++)
            rdchk(6'(4 * k), 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_STATUS, 8'hff);
        rdchk(MULTI_INPUT_WAKEUP_OFF_STATUS, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            bus(1'b1, 6'(4 * k), 8'ha5);
            rdchk(6'(4 * k), 8'ha5);
            bus(1'b1, 6'(4 * k), 8'h00);
        end
    endtask
    task automatic t_edges(input logic [5:0] b, input logic m);
        bus(1'b1, b + 6'h04, 8'h0f);
        bus(1'b1, b + 6'h08, 8'h00);
        pins(m, 8'hff);
        rdchk(b + 6'h08, m ? 8'h70 : 8'hf0);
        bus(1'b1, b + 6'h08, 8'h00);
        rdchk(b + 6'h08, 8'h00);
        pins(m, 8'h00);
        rdchk(b + 6'h08, 8'h0f);
        if (m)
            pins(m, 8'h80);
        bus(1'b1, b + 6'h08, 8'h00);
        bus(1'b1, b + 6'h04, 8'h00);
    endtask
    task automatic t_irq;
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_EN, 8'h01);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_PEND, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, MULTI_INPUT_WAKEUP_OFF_CTRL, 8'(k));
            cyc(2);
            chk("irq", 32'(k == 3), 32'(o_port_irq));
        end
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_EN, 8'h00);
        cyc(2);
        chk("irq", 32'h0, 32'(o_port_irq));
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_PEND, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_EN, 8'h84);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_PEND, 8'h80);
        cyc(2);
        chk("irq", 32'h0, 32'(o_port_irq));
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_PEND, 8'h84);
        cyc(2);
        chk("irq", 32'h1, 32'(o_port_irq));
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_PEND, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_EN, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_EN, 8'h01);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_PEND, 8'h01);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_CTRL, 8'h04);
        cyc(4);
        chk("core_run", 32'h1, 32'(o_core_run));
        rdchk(MULTI_INPUT_WAKEUP_OFF_STATUS, 8'h08);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_PEND, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_EN, 8'h00);
    endtask
    task automatic t_wake(input logic isr);
        int n;
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_PEND, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_EDGE, 8'h80);
        bus(1'b1, isr ? MULTI_INPUT_WAKEUP_OFF_L_EN : MULTI_INPUT_WAKEUP_OFF_M_EN, isr ? 8'h01 : 8'h80);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_CTRL, isr ? 8'h07 : 8'h04);
        cyc(4);
        chk("core_run", 32'h0, 32'(o_core_run));
        rdchk(MULTI_INPUT_WAKEUP_OFF_STATUS, 8'h02);
        @(posedge i_clk);
        if (isr)
            l_lvl <= 8'h01;
        else
            can_dom <= 1'b1;
        n = 0;
        while (o_core_run !== 1'b1 && n < 4000)
        begin
            @(posedge i_clk);
            n++;
        end
        chk("startup", 32'h1, 32'(n >= 2560 && n <= 2580));
        chk("resume_isr", 32'(isr), 32'(o_resume_isr));
        rdchk(isr ? MULTI_INPUT_WAKEUP_OFF_L_PEND : MULTI_INPUT_WAKEUP_OFF_M_PEND, isr ? 8'h01 : 8'h80);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_CTRL, 8'h30);
        cyc(3);
        chk("drive_en", 32'h3, {30'h0, o_en1, o_en0});
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_L_EN, 8'h00);
        bus(1'b1, MULTI_INPUT_WAKEUP_OFF_M_EN, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge i_clk);
        num_errors++;
        results;
    end
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        $display("test registers done");
        t_edges(MULTI_INPUT_WAKEUP_OFF_L_EN, 1'b0);
        t_edges(MULTI_INPUT_WAKEUP_OFF_M_EN, 1'b1);
        $display("test edges done");
        t_irq;
        $display("test interrupt gating done");
        t_wake(1'b0);
        t_wake(1'b1);
        $display("test wake-up done");
        results;
    end
endmodule
bind multi_input_wakeup_top multi_input_wakeup_monitor i_multi_input_wakeup_monitor (.i_clk(i_clk), .i_rst(i_rst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_port_irq(o_port_irq), .o_core_run(o_core_run), .o_resume_isr(o_resume_isr),
    .o_can_drive_enable_0(o_can_drive_enable_0));
`default_nettype wire
